// file: rtl/mgp_params.svh
/*
 Register offsets, field positions and reset values of the port block.
 Assumes inclusion by the port module.
*/
`ifndef MGP_PARAMS_SVH
`define MGP_PARAMS_SVH

`define MGP_ADDR_W          4
`define MGP_OFS_SIX_DATA    4'h0
`define MGP_OFS_SIX_DIR     4'h1
`define MGP_OFS_SIX_PULL    4'h2
`define MGP_OFS_F_DATA      4'h3
`define MGP_OFS_F_DIR       4'h4
`define MGP_OFS_G_DATA      4'h5
`define MGP_OFS_G_DIR       4'h6
`define MGP_OFS_G_PULL      4'h7
`define MGP_OFS_STANDBY     4'h8
`define MGP_OFS_OPEN_DRAIN  4'h9

`define MGP_SIX_MASK        8'hff
`define MGP_SIX_PULL_MASK   8'hfc
`define MGP_F_MASK          8'h07
`define MGP_G_MASK          8'h06
`define MGP_STBY_SPL_BIT    0
`define MGP_DIR_RST         8'h00
`define MGP_DATA_RST        8'h00
`define MGP_PULL_RST        8'h00
`define MGP_OD_RST          8'h00
`define MGP_STBY_RST        8'h00

`endif

// file: rtl/mgp_pkg.sv
/*
 Types shared by the port block.
 Assumes mgp_params.svh sits beside it.
*/
package mgp_pkg;

    // Pin view of one 8-bit port: output, enable and pull-up
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] pull;
    } mgp_pins_t;

    // Peripheral override of one port
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] dat;
    } mgp_perif_t;

    // Per port storage
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pull;
    } mgp_regs_t;

endpackage

// file: rtl/mgp_ports.sv
/*
 Three general purpose ports (eight, three and two pins) with data latch and direction,
 pull-up control and peripheral overrides on the eight- and two-pin ports, and standby isolation.
 Assumes a simple register port with read data one cycle after the strobe,
 pin inputs synchronous to mclk_i, and the standby mode given as a level.
*/
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "mgp_params.svh"

// Contract
// - Direction one drives latch value
// - Direction zero leaves pin undriven
// - Data write always updates latch
// - Output pin read returns latch
// - Input read pin; rmw read latch
// - Peripheral output drives pin; read pin
// - Peripheral input: read pin, rmw latch
// - Reset clears all direction bits
// - Standby with bit set floats pins
// - Enabled interrupt inputs stay unblocked
// - Standby with bit clear holds state
// - Pull-up bit connects pull-up
// - Pull-up off while driving low
// - First port eight pins, bits 0-1 no pull-up
// - Second port bits 0-2, no pull-up
// - Open-drain high releases pin
// - Peripheral enable overrides latch drive
// - Third port data, direction, pull-up
// - Third port uses bits 1 and 2
module mgp_ports (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    // Register port
    input  wire logic [`MGP_ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    input  wire logic                    rmw_i,
    output logic      [7:0]              rdata_o,
    // Standby and interrupt enables
    input  wire logic                    standby_i,
    input  wire logic [1:0]              irq_in_en_i,
    input  wire logic [1:0]              trig_irq_en_i,
    // Peripheral outputs
    input  wire mgp_pkg::mgp_perif_t     perif_six_i,
    input  wire mgp_pkg::mgp_perif_t     perif_g_i,
    // Pins
    input  wire logic [7:0]              six_pin_i,
    input  wire logic [7:0]              f_pin_i,
    input  wire logic [7:0]              g_pin_i,
    output mgp_pkg::mgp_pins_t           six_pins_o,
    output mgp_pkg::mgp_pins_t           f_pins_o,
    output mgp_pkg::mgp_pins_t           g_pins_o,
    // Inputs as seen by the core and peripherals
    output logic      [7:0]              six_in_o,
    output logic      [7:0]              f_in_o,
    output logic      [7:0]              g_in_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    mgp_pkg::mgp_regs_t six_r;
    mgp_pkg::mgp_regs_t f_r;
    mgp_pkg::mgp_regs_t g_r;
    logic [7:0]         stby_r;
    logic [7:0]         od_r;

    wire we_six_d  = wr_i && (addr_i == `MGP_OFS_SIX_DATA);
    wire we_six_dir = wr_i && (addr_i == `MGP_OFS_SIX_DIR);
    wire we_six_p  = wr_i && (addr_i == `MGP_OFS_SIX_PULL);
    wire we_f_d    = wr_i && (addr_i == `MGP_OFS_F_DATA);
    wire we_f_dir  = wr_i && (addr_i == `MGP_OFS_F_DIR);
    wire we_g_d    = wr_i && (addr_i == `MGP_OFS_G_DATA);
    wire we_g_dir  = wr_i && (addr_i == `MGP_OFS_G_DIR);
    wire we_g_p    = wr_i && (addr_i == `MGP_OFS_G_PULL);
    wire we_stby   = wr_i && (addr_i == `MGP_OFS_STANDBY);
    wire we_od     = wr_i && (addr_i == `MGP_OFS_OPEN_DRAIN);

    // Masks keep unused bits at zero on write
    wire [7:0] wd_six  = wdata_i & `MGP_SIX_MASK;
    wire [7:0] wd_six_p = wdata_i & `MGP_SIX_PULL_MASK;
    wire [7:0] wd_f    = wdata_i & `MGP_F_MASK;
    wire [7:0] wd_g    = wdata_i & `MGP_G_MASK;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            six_r  <= {`MGP_DATA_RST, `MGP_DIR_RST, `MGP_PULL_RST};
            f_r    <= {`MGP_DATA_RST, `MGP_DIR_RST, `MGP_PULL_RST};
            g_r    <= {`MGP_DATA_RST, `MGP_DIR_RST, `MGP_PULL_RST};
            stby_r <= `MGP_STBY_RST;
            od_r   <= `MGP_OD_RST;
        end else begin
            if (we_six_d) six_r.data <= wd_six;
            if (we_six_dir) six_r.dir <= wd_six;
            if (we_six_p) six_r.pull <= wd_six_p;
            if (we_f_d)   f_r.data   <= wd_f;
            if (we_f_dir) f_r.dir    <= wd_f;
            if (we_g_d)   g_r.data   <= wd_g;
            if (we_g_dir) g_r.dir    <= wd_g;
            if (we_g_p)   g_r.pull   <= wd_g;
            if (we_stby)  stby_r     <= {7'h00, wdata_i[`MGP_STBY_SPL_BIT]};
            if (we_od)    od_r       <= wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Isolation only with the state bit set; otherwise pins hold as they are
    wire isolate = standby_i && stby_r[`MGP_STBY_SPL_BIT];

    // Peripheral enable wins over the latch; software must clear it first
    wire [7:0] six_drv_en  = perif_six_i.en | six_r.dir;
    wire [7:0] six_drv_val = (perif_six_i.en & perif_six_i.dat) |
                             (~perif_six_i.en & six_r.data);
    wire [7:0] g_drv_en    = (perif_g_i.en & `MGP_G_MASK) | g_r.dir;
    wire [7:0] g_drv_val   = (perif_g_i.en & perif_g_i.dat) | (~perif_g_i.en & g_r.data);
    wire [7:0] f_drv_en    = f_r.dir;
    wire [7:0] f_drv_val   = f_r.data;

    // Open drain: a one releases rather than drives
    wire [7:0] six_oe_nxt  = isolate ? 8'h00 : six_drv_en & ~(od_r & six_drv_val);
    wire [7:0] f_oe_nxt    = isolate ? 8'h00 : f_drv_en & ~(od_r & f_drv_val);
    wire [7:0] g_oe_nxt    = isolate ? 8'h00 : g_drv_en & ~(od_r & g_drv_val);

    // Pull-up only while the pin is not pulled low by us
    wire [7:0] six_pu_nxt  = six_r.pull & `MGP_SIX_PULL_MASK & ~(six_oe_nxt & ~six_drv_val);
    wire [7:0] g_pu_nxt    = g_r.pull & `MGP_G_MASK & ~(g_oe_nxt & ~g_drv_val);

    ////////////////////////////////////////////////////////////////////////////
    // Input blocking

    // Pins 0,1 carry external interrupts; 4 and 7 the counter clock and trigger
    wire [7:0] six_keep = {trig_irq_en_i[1], 2'b00, trig_irq_en_i[0], 2'b00, irq_in_en_i};
    wire [7:0] six_in_nxt = isolate ? (six_pin_i & six_keep) : six_pin_i;
    wire [7:0] f_in_nxt   = isolate ? 8'h00 : (f_pin_i & `MGP_F_MASK);
    wire [7:0] g_in_nxt   = isolate ? 8'h00 : (g_pin_i & `MGP_G_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Plain reads give pin level on inputs and peripheral pins, latch otherwise
    wire [7:0] six_sel_latch = rmw_i ? 8'hff : (six_r.dir & ~perif_six_i.en);
    wire [7:0] g_sel_latch   = rmw_i ? 8'hff : (g_r.dir & ~perif_g_i.en);
    wire [7:0] f_sel_latch   = rmw_i ? 8'hff : f_r.dir;
    wire [7:0] six_rd = (six_sel_latch & six_r.data) | (~six_sel_latch & six_in_o);
    wire [7:0] f_rd   = ((f_sel_latch & f_r.data) | (~f_sel_latch & f_in_o)) & `MGP_F_MASK;
    wire [7:0] g_rd   = ((g_sel_latch & g_r.data) | (~g_sel_latch & g_in_o)) & `MGP_G_MASK;

    logic [7:0] rdata_nxt;
    always_comb begin
        case (addr_i)
            `MGP_OFS_SIX_DATA:   rdata_nxt = six_rd;
            `MGP_OFS_SIX_DIR:    rdata_nxt = six_r.dir;
            `MGP_OFS_SIX_PULL:   rdata_nxt = six_r.pull;
            `MGP_OFS_F_DATA:     rdata_nxt = f_rd;
            `MGP_OFS_F_DIR:      rdata_nxt = f_r.dir;
            `MGP_OFS_G_DATA:     rdata_nxt = g_rd;
            `MGP_OFS_G_DIR:      rdata_nxt = g_r.dir;
            `MGP_OFS_G_PULL:     rdata_nxt = g_r.pull;
            `MGP_OFS_STANDBY:    rdata_nxt = stby_r;
            `MGP_OFS_OPEN_DRAIN: rdata_nxt = od_r;
            default:             rdata_nxt = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers; one cycle of latency from any register change to pins

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o    <= 8'h00;
            six_pins_o <= '0;
            f_pins_o   <= '0;
            g_pins_o   <= '0;
            six_in_o   <= 8'h00;
            f_in_o     <= 8'h00;
            g_in_o     <= 8'h00;
        end else begin
            rdata_o    <= rd_i ? rdata_nxt : 8'h00;
            six_pins_o <= {six_drv_val, six_oe_nxt, six_pu_nxt};
            f_pins_o   <= {f_drv_val & `MGP_F_MASK, f_oe_nxt, 8'h00};
            g_pins_o   <= {g_drv_val & `MGP_G_MASK, g_oe_nxt, g_pu_nxt};
            six_in_o   <= six_in_nxt;
            f_in_o     <= f_in_nxt;
            g_in_o     <= g_in_nxt;
        end
    end

endmodule

// file: tb/mgp_pin_model.sv
/* Pin level model for one port.
 Assumes the pin view struct of the port block. */
`timescale 1ns/1ps
module mgp_pin_model (
    // Port side
    input  wire mgp_pkg::mgp_pins_t pins_i,
    // Outside level
    input  wire logic [7:0]         ext_i,
    // Resolved pin
    output logic      [7:0]         pin_o
);
    // Driver wins, then pull-up, then outside
    assign pin_o = (pins_i.oe & pins_i.dout) | (~pins_i.oe & (pins_i.pull | ext_i));
endmodule

// file: tb/mgp_ports_checker.sv
/* Assertions on the port block.
 Assumes binding to mgp_ports. */
`timescale 1ns/1ps
module mgp_ports_checker (
    input wire logic                mclk_i,
    input wire logic                rst_i,
    input wire logic [3:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic                rmw_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                standby_i,
    input wire mgp_pkg::mgp_perif_t perif_six_i,
    input wire mgp_pkg::mgp_pins_t  six_pins_o,
    input wire mgp_pkg::mgp_pins_t  f_pins_o,
    input wire mgp_pkg::mgp_pins_t  g_pins_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
sequence s_spl_on;
    wr_i && addr_i == 4'h8 && wdata_i[0] ##1 (standby_i && !wr_i)[*2];
endsequence
sequence s_six_wr;
    wr_i && addr_i == 4'h0 ##1 !wr_i && !standby_i && perif_six_i.en == 8'h00;
endsequence
a_dir_clear: assert property ($fell(rst_i) |-> (six_pins_o.oe | f_pins_o.oe | g_pins_o.oe) == 8'h00)
    else $error("pin driven after reset");
a_six_out: assert property (s_six_wr |=> (six_pins_o.dout & six_pins_o.oe) == ($past(wdata_i, 2) & six_pins_o.oe))
    else $error("driven level differs from latch");
a_low_pull: assert property ((six_pins_o.pull & six_pins_o.oe & ~six_pins_o.dout) == 8'h00)
    else $error("pull-up on low pin");
a_six_pull: assert property (six_pins_o.pull[1:0] == 2'b00)
    else $error("pull-up on low pins");
a_f_bits: assert property (f_pins_o.pull == 8'h00 && (f_pins_o.oe & 8'hf8) == 8'h00)
    else $error("unused bit active");
a_g_bits: assert property (((g_pins_o.oe | g_pins_o.pull) & 8'hf9) == 8'h00)
    else $error("unused bit active");
a_rmw_latch: assert property (wr_i && addr_i == 4'h0 ##1 rd_i && rmw_i && addr_i == 4'h0 |=> rdata_o == $past(wdata_i, 2))
    else $error("rmw read not latch");
a_perif_low: assert property ((perif_six_i.en[3] && !perif_six_i.dat[3] && !standby_i)[*2] |-> six_pins_o.oe[3] && !six_pins_o.dout[3])
    else $error("peripheral drive lost");
a_iso_float: assert property (s_spl_on |-> (six_pins_o.oe | f_pins_o.oe | g_pins_o.oe) == 8'h00)
    else $error("pin driven in isolation");
endmodule
bind mgp_ports mgp_ports_checker u_chk (.*);

// file: tb/mgp_ports_tb.sv
/* Self-checking bench for mgp_ports.
 Assumes the pin model and the checker beside it. */
`timescale 1ns/1ps
module mgp_ports_tb;
logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rmw_i = 1'b0, standby_i = 1'b0;
logic [3:0] addr_i = 4'h0;
logic [1:0] irq_in_en_i = 2'h0, trig_irq_en_i = 2'h0;
logic [7:0] wdata_i = 8'h00, six_ext = 8'h00, rdata_o, six_in_o, f_in_o, g_in_o, six_pin_i, f_pin_i, g_pin_i;
mgp_pkg::mgp_perif_t perif_six_i = '0, perif_g_i = '0;
mgp_pkg::mgp_pins_t six_pins_o, f_pins_o, g_pins_o;
int n_fail = 0, check_count = 0, cyc = 0;
always #20 mclk_i = ~mclk_i;
mgp_ports u_dut (.*);
mgp_pin_model u_six (.pins_i(six_pins_o), .ext_i(six_ext), .pin_o(six_pin_i));
mgp_pin_model u_f (.pins_i(f_pins_o), .ext_i(8'h00), .pin_o(f_pin_i));
mgp_pin_model u_g (.pins_i(g_pins_o), .ext_i(8'h00), .pin_o(g_pin_i));
task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
        n_fail++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, input logic m, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    rmw_i <= m;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    rmw_i <= 1'b0;
    #1 chk(rdata_o, exp);
endtask
task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
endtask
task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
////////////////////////////////////////////////////////////////
task automatic t_regs;
    rd(4'h1, 0, 8'h00);
    rd(4'h4, 0, 8'h00);
    rd(4'h6, 0, 8'h00);
    rd(4'hf, 0, 8'h00);
    wr(4'h1, 8'hff);
    wr(4'h0, 8'ha5);
    wr(4'h2, 8'hff);
    idle(2);
    chk(six_pins_o.oe, 8'hff);
    chk(six_pins_o.pull, 8'ha4);
    rd(4'h0, 0, 8'ha5);
    rd(4'h2, 0, 8'hfc);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h3c);
    six_ext <= 8'h5a;
    idle(3);
    chk(six_pins_o.oe, 8'h00);
    rd(4'h0, 0, 8'h5a);
    rd(4'h0, 1, 8'h3c);
    $display("register test done");
endtask
task automatic t_perif;
    wr(4'h1, 8'hff);
    wr(4'h0, 8'hff);
    perif_six_i <= '{en: 8'h08, dat: 8'h00};
    idle(3);
    chk({6'h00, six_pins_o.oe[3], six_pins_o.dout[3]}, 8'h02);
    rd(4'h0, 0, 8'hf7);
    rd(4'h0, 1, 8'hff);
    perif_six_i <= '0;
    wr(4'h4, 8'hff);
    wr(4'h6, 8'hff);
    wr(4'h7, 8'hff);
    wr(4'h5, 8'hff);
    rd(4'h4, 0, 8'h07);
    rd(4'h7, 0, 8'h06);
    rd(4'h5, 1, 8'h06);
    chk(g_pins_o.oe, 8'h06);
    wr(4'h9, 8'h01);
    idle(2);
    chk(six_pins_o.oe, 8'hfe);
    wr(4'h9, 8'h00);
    $display("peripheral test done");
endtask
task automatic t_stby;
    standby_i <= 1'b1;
    idle(3);
    chk(six_pins_o.oe, 8'hff);
    standby_i <= 1'b0;
    six_ext <= 8'hff;
    irq_in_en_i <= 2'b01;
    trig_irq_en_i <= 2'b10;
    wr(4'h8, 8'h01);
    standby_i <= 1'b1;
    idle(3);
    chk(six_pins_o.oe | f_pins_o.oe | g_pins_o.oe, 8'h00);
    chk(six_in_o, 8'h81);
    chk(g_in_o, 8'h00);
    standby_i <= 1'b0;
    $display("standby test done");
endtask
task automatic t_more;
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= 4'h0;
    wdata_i <= 8'h69;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    rmw_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    rmw_i <= 1'b0;
    #1 chk(rdata_o, 8'h69);
    perif_g_i <= '{en: 8'h02, dat: 8'h00};
    wr(4'h3, 8'h07);
    idle(3);
    chk(g_pins_o.oe, 8'h06);
    chk(g_pins_o.dout, 8'h04);
    chk(g_pins_o.pull, 8'h04);
    rd(4'h5, 0, 8'h04);
    chk(f_pins_o.dout, 8'h07);
    chk(f_in_o, 8'h07);
    perif_g_i <= '0;
    wr(4'h1, 8'h00);
    irq_in_en_i <= 2'b10;
    trig_irq_en_i <= 2'b01;
    standby_i <= 1'b1;
    idle(3);
    chk(six_in_o, 8'h12);
    standby_i <= 1'b0;
    $display("extra test done");
endtask
always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
        n_fail++;
        report_and_stop();
    end
end
initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_perif();
    t_stby();
    t_more();
    report_and_stop();
end
endmodule
